// ### logic/cmr_pkg.sv
// package: constants and types of the instruction execution slice
// Operation
// RL1 - supervisor alternate_space_transfer user stack pointer to or from a register, else traps
// RL2 - supervisor alternate_space_transfer control register to or from a register, else traps
// RL3 - supervisor alternate-space transfer tagged by function code, else traps
// RL4 - multiply forms: 16x16 to 32, 32x32 to 32, 32x32 to 64 pair
// RL5 - signed multiply uses two's complement, unsigned uses magnitudes
// RL6 - decimal negate: zero minus packed-decimal destination minus extend
// RL7 - binary negate: zero minus destination
// RL8 - negate with extend: zero minus destination minus extend
// RL9 - or of source and destination; not complements its operand
// RL10 - or-immediate combines immediate with destination
// RL11 - or to condition byte always allowed; to status word supervisor only
// RL12 - push address: stack pointer minus four, store the address itself
// RL13 - reset instruction drives reset output in supervisor, else traps
// RL14 - plain rotate by register, immediate or memory count, no extend
// RL15 - rotate through extend includes extend flag, same three count forms
// RL16 - direction bit selects left or right rotation
// RL17 - return and deallocate: pop pc, add four plus displacement
// RL18 - exception return pops status word, pc, frees frame by format
// RL19 - return restoring codes: pop condition byte, then pc
// RL20 - multi-register transfer stores or loads a selected register list
// RL21 - quick load puts instruction immediate into a data register
// RL22 - privileged trap in user state changes no register, memory or pin
package cmr_pkg;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_OPER = 8'h04;
  localparam logic [7:0] A_SRC  = 8'h08;
  localparam logic [7:0] A_DST  = 8'h0c;
  localparam logic [7:0] A_AUX  = 8'h10;
  localparam logic [7:0] A_RLO  = 8'h14;
  localparam logic [7:0] A_RHI  = 8'h18;
  localparam logic [7:0] A_STAT = 8'h1c;
  localparam logic [7:0] A_SP   = 8'h20;
  localparam logic [7:0] A_USTK = 8'h24;
  localparam logic [7:0] A_CREG = 8'h28;
  localparam logic [7:0] A_SWRD = 8'h2c;
  localparam logic [7:0] A_PC   = 8'h30;
  localparam logic [7:0] A_FC   = 8'h34;
  localparam logic [2:0] A_GP_HI = 3'h2;
  localparam int CB_GO = 0;
  localparam int CB_SUP = 1;
  localparam int CB_STORE = 2;
  localparam int CB_LEFT = 3;
  localparam int XB = 4;
  localparam logic [1:0] FORM_WORD = 2'h0;
  localparam logic [1:0] FORM_LONG = 2'h1;
  localparam logic [1:0] FORM_PAIR = 2'h2;
  localparam logic [31:0] STEP_W = 32'h2;
  localparam logic [31:0] STEP_L = 32'h4;
  localparam logic [31:0] FRAME_SHORT = 32'h8;
  localparam logic [31:0] FRAME_EXTRA = 32'h4;
  localparam logic [3:0] FMT_LONG = 4'h2;
  localparam logic [5:0] IMM_ZERO_CNT = 6'h8;
  localparam logic [4:0] RESET_HOLD = 5'h10;
  typedef enum logic [4:0] {
    OP_NOP, OP_USER_SP, OP_CTL_MOVE, OP_ALT_MOVE, OP_MUL_S, OP_MUL_U,
    OP_DEC_NEG, OP_TWOS, OP_TWOS_X, OP_OR, OP_NOT, OP_OR_IMM, OP_OR_CCB,
    OP_OR_SWRD, OP_PUSH_EA, OP_RESET, OP_ROT, OP_ROT_X, OP_RET_DEALLOC,
    OP_RET_EXC, OP_RET_CODES, OP_MULTI, OP_QUICK
  } cmr_op_e;
  typedef enum logic [1:0] {S_IDLE, S_EXEC, S_LIST} cmr_state_e;
endpackage : cmr_pkg

// ### logic/cmr_core.sv
// execution slice with wishbone register file and on-chip stack memory
//
// The Wishbone slave port and the register offsets were left to the implementer.
`timescale 1ns/100ps
module cmr_core import cmr_pkg::*; (
  input  wire logic        MCLK_I,      // 25 MHz clock
  input  wire logic        NRST_I,      // async reset, low
  input  wire logic        WB_CYC_I,    // bus cycle
  input  wire logic        WB_STB_I,    // strobe
  input  wire logic        WB_WE_I,     // write enable
  input  wire logic [7:0]  WB_ADR_I,    // byte address
  input  wire logic [31:0] WB_DAT_I,    // write data
  input  wire logic [3:0]  WB_SEL_I,    // byte lanes
  output logic      [31:0] WB_DAT_O,    // read data
  output logic             WB_ACK_O,    // acknowledge
  output logic             RESET_OUT_O  // external reset, high
);
  logic        req;
  logic        wr;
  logic [3:0]  ctrl;
  logic [6:0]  oper;
  logic [31:0] src;
  logic [31:0] dst;
  logic [31:0] aux;
  logic [31:0] res_lo;
  logic [31:0] res_hi;
  logic        done;
  logic        trap;
  logic [31:0] sp;
  logic [31:0] user_stack_pointer;
  logic [31:0] control_register;
  logic [15:0] status_word;
  logic [31:0] pc;
  logic [2:0]  source_function_code;
  logic [2:0]  dest_function_code;
  logic [31:0] gp [8];
  logic [15:0] stk [32];
  logic [2:0]  lc;
  logic [31:0] mptr;
  logic [4:0]  rst_cnt;
  logic [31:0] rd_mux;
  cmr_state_e  state;
  cmr_op_e     op;
  logic [1:0]  form;
  logic        sup;
  logic        priv;
  logic        bad;
  logic        fin;
  logic        go;
  logic [31:0] next_sp;
  logic [31:0] next_usp;
  logic [31:0] next_creg;
  logic [15:0] next_swrd;
  logic [31:0] next_pc;
  logic [31:0] next_rlo;
  logic [31:0] next_rhi;
  logic [31:0] next_mptr;
  logic        next_trap;
  logic        mw_en;
  logic [31:0] mw_adr;
  logic [31:0] mw_val;
  logic        gw_en;
  logic [2:0]  gw_idx;
  logic [31:0] gw_val;
  logic        rst_go;
  logic signed [64:0]  ma;
  logic signed [64:0]  mb;
  logic signed [129:0] mprod;
  logic [5:0]  cnt;
  logic [32:0] rot_v;
  logic [32:0] diff;
  logic [8:0]  dec_v;
  logic [3:0]  fmt;

  function automatic logic [31:0] lanes(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) r[b*8 +: 8] = n[b*8 +: 8];
    end
    return r;
  endfunction : lanes

  function automatic logic [31:0] rdl(input logic [31:0] a);
    return {stk[a[5:1]], stk[a[5:1] + 5'h1]};
  endfunction : rdl

  function automatic logic [8:0] dec_neg(input logic [7:0] d, input logic x);
    logic [4:0] lo;
    logic [4:0] hi;
    logic       bl;
    logic       bh;
    lo = 5'h0 - {1'b0, d[3:0]} - {4'h0, x};
    bl = lo[4];
    if (bl) lo = lo - 5'h6;
    hi = 5'h0 - {1'b0, d[7:4]} - {4'h0, bl};
    bh = hi[4];
    if (bh) hi = hi - 5'h6;
    return {bh, hi[3:0], lo[3:0]};
  endfunction : dec_neg

  // bit 32 carries the extend or last bit shifted out
  function automatic logic [32:0] rot(input logic [31:0] d, input logic x,
                                      input logic [5:0] c, input logic l, input logic t);
    logic [32:0] v;
    v = {x, d};
    for (int i = 0; i < 64; i++) begin
      if (i < c) begin
        if (t && l) v = {v[31:0], v[32]};
        else if (t) v = {v[0], v[32:1]};
        else if (l) v = {v[31], v[30:0], v[31]};
        else v = {v[0], v[0], v[31:1]};
      end
    end
    return v;
  endfunction : rot

  assign req  = WB_CYC_I & WB_STB_I;
  // writes land on the edge where the master sees ack
  assign wr   = req & WB_WE_I & WB_ACK_O;
  assign op   = cmr_op_e'(oper[4:0]);
  assign form = oper[6:5];
  assign sup  = ctrl[CB_SUP];
  assign go   = wr && WB_ADR_I == A_CTRL && WB_SEL_I[0] && WB_DAT_I[CB_GO];
  assign priv = op inside {OP_USER_SP, OP_CTL_MOVE, OP_ALT_MOVE, OP_OR_SWRD, OP_RESET,
                           OP_RET_EXC};
  // RL22 trap gate
  assign bad  = (state == S_EXEC) && priv && !sup;
  assign fin  = (state == S_EXEC && op != OP_MULTI) || (state == S_LIST && lc == 3'h7);

  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) WB_ACK_O <= 1'b0;
    else WB_ACK_O <= req & ~WB_ACK_O;
  end

  always_comb begin
    rd_mux = 32'h0;
    if (WB_ADR_I[7]) rd_mux = {16'h0, stk[WB_ADR_I[6:2]]};
    else if (WB_ADR_I[7:5] == A_GP_HI) rd_mux = gp[WB_ADR_I[4:2]];
    else begin
      unique case (WB_ADR_I)
        A_CTRL: rd_mux = {28'h0, ctrl[3:1], 1'b0};
        A_OPER: rd_mux = {25'h0, oper};
        A_SRC:  rd_mux = src;
        A_DST:  rd_mux = dst;
        A_AUX:  rd_mux = aux;
        A_RLO:  rd_mux = res_lo;
        A_RHI:  rd_mux = res_hi;
        A_STAT: rd_mux = {28'h0, RESET_OUT_O, state != S_IDLE, trap, done};
        A_SP:   rd_mux = sp;
        A_USTK: rd_mux = user_stack_pointer;
        A_CREG: rd_mux = control_register;
        A_SWRD: rd_mux = {16'h0, status_word};
        A_PC:   rd_mux = pc;
        A_FC:   rd_mux = {25'h0, dest_function_code, 1'b0, source_function_code};
        default: rd_mux = 32'h0;
      endcase
    end
  end

  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) WB_DAT_O <= 32'h0;
    else if (req && !WB_ACK_O) WB_DAT_O <= rd_mux;
  end

  // operand and control registers, software only
  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ctrl <= 4'h0;
      oper <= 7'h0;
      src <= 32'h0;
      dst <= 32'h0;
      aux <= 32'h0;
      source_function_code <= 3'h0;
      dest_function_code <= 3'h0;
    end else if (wr && state == S_IDLE) begin
      unique case (WB_ADR_I)
        A_CTRL: if (WB_SEL_I[0]) ctrl <= {WB_DAT_I[3:1], 1'b0};
        A_OPER: if (WB_SEL_I[0]) oper <= WB_DAT_I[6:0];
        A_SRC:  src <= lanes(src, WB_DAT_I, WB_SEL_I);
        A_DST:  dst <= lanes(dst, WB_DAT_I, WB_SEL_I);
        A_AUX:  aux <= lanes(aux, WB_DAT_I, WB_SEL_I);
        A_FC: begin
          if (WB_SEL_I[0]) source_function_code <= WB_DAT_I[2:0];
          if (WB_SEL_I[0]) dest_function_code <= WB_DAT_I[6:4];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) state <= S_IDLE;
    else begin
      unique case (state)
        S_IDLE: if (go) state <= S_EXEC;
        S_EXEC: state <= (op == OP_MULTI) ? S_LIST : S_IDLE;
        S_LIST: if (lc == 3'h7) state <= S_IDLE;
      endcase
    end
  end

  always_comb begin
    cnt = 6'h1;
    if (form == FORM_WORD) cnt = src[5:0];
    else if (form == FORM_LONG) cnt = (aux[2:0] == 3'h0) ? IMM_ZERO_CNT : {3'h0, aux[2:0]};
    // RL14 count source
    // RL16 direction select
    rot_v = rot(dst, status_word[XB], cnt, ctrl[CB_LEFT], op == OP_ROT_X);
    // RL5 operand extension
    ma = (form == FORM_WORD) ? {{49{op == OP_MUL_S && src[15]}}, src[15:0]}
                             : {{33{op == OP_MUL_S && src[31]}}, src};
    mb = (form == FORM_WORD) ? {{49{op == OP_MUL_S && dst[15]}}, dst[15:0]}
                             : {{33{op == OP_MUL_S && dst[31]}}, dst};
    mprod = ma * mb;
    diff = 33'h0 - {1'b0, dst} - {32'h0, op == OP_TWOS_X && status_word[XB]};
    dec_v = dec_neg(dst[7:0], status_word[XB]);
    fmt = stk[5'(sp[5:1] + 5'h3)][15:12];
  end

  always_comb begin
    next_sp = sp;
    next_usp = user_stack_pointer;
    next_creg = control_register;
    next_swrd = status_word;
    next_pc = pc;
    next_rlo = res_lo;
    next_rhi = res_hi;
    next_mptr = mptr;
    next_trap = 1'b0;
    mw_en = 1'b0;
    mw_adr = dst;
    mw_val = src;
    gw_en = 1'b0;
    gw_idx = lc;
    gw_val = rdl(mptr);
    rst_go = 1'b0;
    if (bad) next_trap = 1'b1;
    else if (state == S_LIST) begin
      // RL20 list walk
      if (aux[lc]) begin
        mw_en = ctrl[CB_STORE];
        mw_adr = mptr;
        mw_val = gp[lc];
        gw_en = !ctrl[CB_STORE];
        next_mptr = mptr + STEP_L;
      end
    end else if (state == S_EXEC) begin
      unique case (op)
        OP_NOP: ;
        // RL1 user stack move
        OP_USER_SP: if (ctrl[CB_STORE]) next_usp = src; else next_rlo = user_stack_pointer;
        // RL2 control move
        OP_CTL_MOVE: if (ctrl[CB_STORE]) next_creg = src; else next_rlo = control_register;
        OP_ALT_MOVE: begin
          // RL3 qualified space
          if (ctrl[CB_STORE]) begin
            mw_en = 1'b1;
            next_rhi = {29'h0, dest_function_code};
          end else begin
            next_rlo = rdl(src);
            next_rhi = {29'h0, source_function_code};
          end
        end
        OP_MUL_S, OP_MUL_U: begin
          // RL4 product forms
          next_rlo = mprod[31:0];
          if (form == FORM_PAIR) next_rhi = mprod[63:32];
        end
        OP_DEC_NEG: begin
          // RL6 decimal negate
          next_rlo = {dst[31:8], dec_v[7:0]};
          next_swrd[XB] = dec_v[8];
        end
        OP_TWOS, OP_TWOS_X: begin
          // RL7 RL8 negate
          next_rlo = diff[31:0];
          next_swrd[XB] = diff[32];
        end
        // RL9 or and not
        OP_OR: next_rlo = src | dst;
        OP_NOT: next_rlo = ~dst;
        // RL10 immediate or
        OP_OR_IMM: next_rlo = aux | dst;
        // RL11 status or
        OP_OR_CCB: next_swrd[7:0] = status_word[7:0] | src[7:0];
        OP_OR_SWRD: next_swrd = status_word | src[15:0];
        OP_PUSH_EA: begin
          // RL12 push address
          next_sp = sp - STEP_L;
          mw_en = 1'b1;
          mw_adr = sp - STEP_L;
        end
        // RL13 reset pin
        OP_RESET: rst_go = 1'b1;
        OP_ROT, OP_ROT_X: begin
          // RL14 RL15 rotate
          next_rlo = rot_v[31:0];
          if (op == OP_ROT_X) next_swrd[XB] = rot_v[32];
        end
        OP_RET_DEALLOC: begin
          // RL17 pop and free
          next_pc = rdl(sp);
          next_sp = sp + STEP_L + {{16{aux[15]}}, aux[15:0]};
        end
        OP_RET_EXC: begin
          // RL18 frame pop
          next_swrd = stk[sp[5:1]];
          next_pc = rdl(sp + STEP_W);
          next_sp = sp + FRAME_SHORT + ((fmt == FMT_LONG) ? FRAME_EXTRA : 32'h0);
        end
        OP_RET_CODES: begin
          // RL19 codes then pc
          next_swrd[7:0] = stk[sp[5:1]][7:0];
          next_pc = rdl(sp + STEP_W);
          next_sp = sp + STEP_W + STEP_L;
        end
        OP_MULTI: next_mptr = dst;
        OP_QUICK: begin
          // RL21 quick load
          gw_en = 1'b1;
          gw_idx = dst[2:0];
          gw_val = {{24{aux[7]}}, aux[7:0]};
          next_rlo = gw_val;
        end
        default: ;
      endcase
    end
  end

  // exec owns the state while busy; software writes only when idle
  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      sp <= 32'h0;
      user_stack_pointer <= 32'h0;
      control_register <= 32'h0;
      status_word <= 16'h0;
      pc <= 32'h0;
      res_lo <= 32'h0;
      res_hi <= 32'h0;
      mptr <= 32'h0;
    end else if (state != S_IDLE) begin
      sp <= next_sp;
      user_stack_pointer <= next_usp;
      control_register <= next_creg;
      status_word <= next_swrd;
      pc <= next_pc;
      res_lo <= next_rlo;
      res_hi <= next_rhi;
      mptr <= next_mptr;
    end else if (wr) begin
      unique case (WB_ADR_I)
        A_SP:   sp <= lanes(sp, WB_DAT_I, WB_SEL_I);
        A_USTK: user_stack_pointer <= lanes(user_stack_pointer, WB_DAT_I, WB_SEL_I);
        A_CREG: control_register <= lanes(control_register, WB_DAT_I, WB_SEL_I);
        A_SWRD: status_word <= 16'(lanes({16'h0, status_word}, WB_DAT_I, WB_SEL_I));
        A_PC:   pc <= lanes(pc, WB_DAT_I, WB_SEL_I);
        default: ;
      endcase
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (mw_en) begin
      stk[mw_adr[5:1]] <= mw_val[31:16];
      stk[5'(mw_adr[5:1] + 5'h1)] <= mw_val[15:0];
    end else if (wr && state == S_IDLE && WB_ADR_I[7]) begin
      stk[WB_ADR_I[6:2]] <= 16'(lanes({16'h0, stk[WB_ADR_I[6:2]]}, WB_DAT_I, WB_SEL_I));
    end
    if (gw_en) gp[gw_idx] <= gw_val;
    else if (wr && state == S_IDLE && WB_ADR_I[7:5] == A_GP_HI) begin
      gp[WB_ADR_I[4:2]] <= lanes(gp[WB_ADR_I[4:2]], WB_DAT_I, WB_SEL_I);
    end
  end

  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) lc <= 3'h0;
    else if (state == S_LIST) lc <= lc + 3'h1;
    else lc <= 3'h0;
  end

  // sticky flags: a new event beats a write-one clear
  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      done <= 1'b0;
      trap <= 1'b0;
    end else begin
      done <= fin | (done & ~(wr && WB_ADR_I == A_STAT && WB_SEL_I[0] && WB_DAT_I[0]));
      trap <= next_trap | (trap & ~(wr && WB_ADR_I == A_STAT && WB_SEL_I[0] && WB_DAT_I[1]));
    end
  end

  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rst_cnt <= 5'h0;
      RESET_OUT_O <= 1'b0;
    end else if (rst_go) begin
      rst_cnt <= RESET_HOLD;
      RESET_OUT_O <= 1'b1;
    end else if (rst_cnt != 5'h0) begin
      rst_cnt <= rst_cnt - 5'h1;
      RESET_OUT_O <= rst_cnt > 5'h1;
    end
  end

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!NRST_I);

  sequence s_exec(cmr_op_e o);
    state == S_EXEC && op == o;
  endsequence
  sequence s_list_back;
    ##[8:9] state == S_IDLE && done;
  endsequence

  AST_PRIV_HOLD: assert property (bad |=> trap && sp == $past(sp) &&  // RL22
    user_stack_pointer == $past(user_stack_pointer) && !$rose(RESET_OUT_O))
    else $error("privileged trap changed state");
  AST_USER_SP: assert property (s_exec(OP_USER_SP) and ##0 sup && !ctrl[CB_STORE]  // RL1
    |=> res_lo == $past(user_stack_pointer)) else $error("user stack read wrong");
  AST_MUL_PAIR: assert property (s_exec(OP_MUL_U) and ##0 form == FORM_PAIR  // RL4
    |=> {res_hi, res_lo} == 64'($past(src)) * 64'($past(dst)))
    else $error("unsigned pair product wrong");
  AST_TWOS: assert property (s_exec(OP_TWOS)  // RL7
    |=> res_lo == 32'(32'h0 - $past(dst))) else $error("negate wrong");
  AST_CCB: assert property (s_exec(OP_OR_CCB)  // RL11
    |=> !trap && status_word[7:0] == ($past(status_word[7:0]) | $past(src[7:0])))
    else $error("condition byte or wrong");
  AST_PUSH: assert property (s_exec(OP_PUSH_EA)  // RL12
    |=> sp == $past(sp) - STEP_L && rdl(sp) == $past(src)) else $error("push wrong");
  AST_RESET_ON: assert property (s_exec(OP_RESET) and ##0 sup  // RL13
    |=> RESET_OUT_O [*8]) else $error("reset output not held");
  AST_RESET_OFF: assert property (s_exec(OP_RESET) and ##0 !sup && !RESET_OUT_O  // RL13
    |=> !RESET_OUT_O) else $error("reset output in user state");
  AST_DEALLOC: assert property (s_exec(OP_RET_DEALLOC)  // RL17
    |=> sp == $past(sp) + STEP_L + {{16{$past(aux[15])}}, $past(aux[15:0])})
    else $error("deallocate wrong");
  AST_CODES: assert property (s_exec(OP_RET_CODES)  // RL19
    |=> sp == $past(sp) + 32'h6) else $error("codes return wrong");
  AST_LIST: assert property (s_exec(OP_MULTI) |-> s_list_back)  // RL20
    else $error("register list walk length wrong");
endmodule : cmr_core

// ### tb/cmr_periph_model.sv
// partner model: peripheral that watches the external reset output
`timescale 1ns/100ps
module cmr_periph_model (
  input  wire logic clk_i,         // bench clock
  input  wire logic nrst_i,        // async reset, low
  input  wire logic reset_in_i,    // external reset from the core
  output int        pulse_count_o, // completed reset pulses
  output int        last_width_o   // cycles of the last pulse
);
  int run_len;

  // counts each reset pulse and how long it stands
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      run_len       <= 0;
      pulse_count_o <= 0;
      last_width_o  <= 0;
    end else if (reset_in_i === 1'b1) begin
      run_len <= run_len + 1;
    end else begin
      if (run_len != 0) begin
        pulse_count_o <= pulse_count_o + 1;
        last_width_o  <= run_len;
      end
      run_len <= 0;
    end
  end
endmodule : cmr_periph_model

// ### tb/cmr_core_test.sv
// testbench: register-level checks of the execution slice
`timescale 1ns/100ps
module cmr_core_test import cmr_pkg::*;;
  logic        clk  = 1'b0;
  logic        nrst = 1'b0;
  logic        cyc  = 1'b0;
  logic        stb  = 1'b0;
  logic        we   = 1'b0;
  logic [7:0]  adr  = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0]  sel  = 4'h0;
  logic [31:0] dout;
  logic        ack;
  logic        rst_out;
  logic [31:0] rdat;
  logic [31:0] res;
  logic [31:0] st;
  int          pulses;
  int          width;
  int          fail_count = 0;
  int          checked = 0;

  always #20 clk = ~clk;

  cmr_core DUT (
    .MCLK_I(clk), .NRST_I(nrst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_SEL_I(sel), .WB_DAT_O(dout),
    .WB_ACK_O(ack), .RESET_OUT_O(rst_out)
  );

  cmr_periph_model PERIPH (
    .clk_i(clk), .nrst_i(nrst), .reset_in_i(rst_out),
    .pulse_count_o(pulses), .last_width_o(width)
  );

  task report_and_stop;
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one classic cycle; request held until ack is sampled high
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'hf;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rdat = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    if (n >= 50) begin
      fail_count++;
      $display("ERROR %0t: bus timeout", $time);
      report_and_stop();
    end
  endtask : xfer

  // load operands, start, poll done or trap, fetch low result
  task run(input logic [4:0] op, input logic [1:0] form, input logic [31:0] ctrl,
           input logic [31:0] s, input logic [31:0] d, input logic [31:0] a);
    int n;
    xfer(1'b1, A_SRC, s);
    xfer(1'b1, A_DST, d);
    xfer(1'b1, A_AUX, a);
    xfer(1'b1, A_OPER, {25'h0, form, op});
    xfer(1'b1, A_STAT, 32'h3);
    xfer(1'b1, A_CTRL, ctrl | 32'h1);
    n = 0;
    do begin
      xfer(1'b0, A_STAT, 32'h0);
      n++;
    end while (rdat[1:0] === 2'b00 && n < 20);
    st = rdat & 32'h3;
    if (n >= 20) begin
      fail_count++;
      $display("ERROR %0t: operation never finished", $time);
      report_and_stop();
    end
    xfer(1'b0, A_RLO, 32'h0);
    res = rdat;
  endtask : run

  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    run(OP_OR, FORM_WORD, 32'h0, 32'hf0f0_0000, 32'h0f00_00ff, 32'h0);
    chk(res, 32'hfff0_00ff);
    run(OP_NOT, FORM_WORD, 32'h0, 32'h0, 32'h1234_5678, 32'h0);
    chk(res, 32'hedcb_a987);
    run(OP_TWOS, FORM_WORD, 32'h0, 32'h0, 32'h0000_0005, 32'h0);
    chk(res, 32'hffff_fffb);
    xfer(1'b1, A_SWRD, 32'h10);
    run(OP_TWOS_X, FORM_WORD, 32'h0, 32'h0, 32'h0000_0005, 32'h0);
    chk(res, 32'hffff_fffa);
    xfer(1'b1, A_SWRD, 32'h0);
    run(OP_DEC_NEG, FORM_WORD, 32'h0, 32'h0, 32'h0000_0025, 32'h0);
    chk(res, 32'h0000_0075);
    run(OP_MUL_U, FORM_PAIR, 32'h0, 32'hffff_ffff, 32'h2, 32'h0);
    chk(res, 32'hffff_fffe);
    xfer(1'b0, A_RHI, 32'h0);
    chk(rdat, 32'h0000_0001);
    run(OP_MUL_S, FORM_PAIR, 32'h0, 32'hffff_ffff, 32'h2, 32'h0);
    xfer(1'b0, A_RHI, 32'h0);
    chk(rdat, 32'hffff_ffff);
    run(OP_MUL_S, FORM_WORD, 32'h0, 32'h0000_ffff, 32'h3, 32'h0);
    chk(res, 32'hffff_fffd);
    run(OP_MUL_U, FORM_WORD, 32'h0, 32'h0000_ffff, 32'h3, 32'h0);
    chk(res, 32'h0002_fffd);
    run(OP_MUL_U, FORM_LONG, 32'h0, 32'h0001_0000, 32'h0001_0001, 32'h0);
    chk(res, 32'h0001_0000);
    run(OP_QUICK, FORM_WORD, 32'h0, 32'h0, 32'h3, 32'h80);
    xfer(1'b0, 8'h4c, 32'h0);
    chk(rdat, 32'hffff_ff80);
    run(OP_ROT, FORM_WORD, 32'h8, 32'h1, 32'h8000_0001, 32'h0);
    chk(res, 32'h0000_0003);
    run(OP_ROT, FORM_LONG, 32'h0, 32'h0, 32'h0000_00ff, 32'h0);
    chk(res, 32'hff00_0000);
    run(OP_ROT, FORM_PAIR, 32'h0, 32'h0, 32'h0000_0001, 32'h0);
    chk(res, 32'h8000_0000);
    // decimal negate left the extend flag set; start this rotate with it clear
    xfer(1'b1, A_SWRD, 32'h0);
    run(OP_ROT_X, FORM_WORD, 32'h8, 32'h1, 32'h8000_0000, 32'h0);
    chk(res, 32'h0000_0000);
    xfer(1'b0, A_SWRD, 32'h0);
    chk(rdat & 32'h10, 32'h10);
    // privileged attempts in user state must change nothing but trap and done
    xfer(1'b1, A_USTK, 32'h0000_0040);
    run(OP_USER_SP, FORM_WORD, 32'h0, 32'h0, 32'h0, 32'h0);
    // a refused op still raises done alongside trap
    chk(st, 32'h3);
    chk(res, 32'h0000_0000);
    xfer(1'b0, A_USTK, 32'h0);
    chk(rdat, 32'h0000_0040);
    run(OP_RESET, FORM_WORD, 32'h0, 32'h0, 32'h0, 32'h0);
    chk(st, 32'h3);
    chk(32'(pulses), 32'h0);
    run(OP_RESET, FORM_WORD, 32'h2, 32'h0, 32'h0, 32'h0);
    repeat (24) @(posedge clk);
    chk(32'(pulses), 32'h1);
    chk(32'(width), 32'(RESET_HOLD));
    xfer(1'b1, A_SWRD, 32'h0);
    run(OP_OR_CCB, FORM_WORD, 32'h0, 32'h05, 32'h0, 32'h0);
    xfer(1'b0, A_SWRD, 32'h0);
    chk(rdat, 32'h0000_0005);
    run(OP_OR_SWRD, FORM_WORD, 32'h0, 32'h2000, 32'h0, 32'h0);
    chk(st, 32'h3);
    xfer(1'b0, A_SWRD, 32'h0);
    chk(rdat, 32'h0000_0005);
    xfer(1'b1, A_SP, 32'h0000_0020);
    run(OP_PUSH_EA, FORM_WORD, 32'h0, 32'h0, 32'h0, 32'h0000_1234);
    xfer(1'b0, A_SP, 32'h0);
    chk(rdat, 32'h0000_001c);
    xfer(1'b1, A_SP, 32'h0000_0010);
    xfer(1'b1, 8'ha0, 32'h0000_1234);
    xfer(1'b1, 8'ha4, 32'h0000_5678);
    run(OP_RET_DEALLOC, FORM_WORD, 32'h0, 32'h0, 32'h0, 32'h0000_0008);
    xfer(1'b0, A_PC, 32'h0);
    chk(rdat, 32'h1234_5678);
    xfer(1'b0, A_SP, 32'h0);
    chk(rdat, 32'h0000_001c);
    run(OP_OR_IMM, FORM_WORD, 32'h0, 32'h0, 32'h0000_0f00, 32'h0000_00f0);
    chk(res, 32'h0000_0ff0);
    // supervisor forms of the privileged alternate_space_transfer
    run(OP_USER_SP, FORM_WORD, 32'h2, 32'h0, 32'h0, 32'h0);
    chk(res, 32'h0000_0040);
    run(OP_USER_SP, FORM_WORD, 32'h6, 32'h0000_0088, 32'h0, 32'h0);
    xfer(1'b0, A_USTK, 32'h0);
    chk(rdat, 32'h0000_0088);
    run(OP_CTL_MOVE, FORM_WORD, 32'h6, 32'h0000_abcd, 32'h0, 32'h0);
    run(OP_CTL_MOVE, FORM_WORD, 32'h2, 32'h0, 32'h0, 32'h0);
    chk(res, 32'h0000_abcd);
    xfer(1'b1, A_FC, 32'h0000_0053);
    run(OP_ALT_MOVE, FORM_WORD, 32'h2, 32'h0000_0010, 32'h0, 32'h0);
    chk(res, 32'h1234_5678);
    xfer(1'b0, A_RHI, 32'h0);
    chk(rdat, 32'h0000_0003);
    run(OP_ALT_MOVE, FORM_WORD, 32'h6, 32'hcafe_0001, 32'h0000_0030, 32'h0);
    xfer(1'b0, A_RHI, 32'h0);
    chk(rdat, 32'h0000_0005);
    xfer(1'b0, 8'he0, 32'h0);
    chk(rdat, 32'h0000_cafe);
    // codes return: byte from the slot at sp, pc from sp+2
    xfer(1'b1, A_SP, 32'h0000_0010);
    xfer(1'b1, 8'ha8, 32'h0000_9abc);
    run(OP_RET_CODES, FORM_WORD, 32'h0, 32'h0, 32'h0, 32'h0);
    xfer(1'b0, A_PC, 32'h0);
    chk(rdat, 32'h5678_9abc);
    xfer(1'b0, A_SWRD, 32'h0);
    chk(rdat, 32'h0000_0034);
    xfer(1'b0, A_SP, 32'h0);
    chk(rdat, 32'h0000_0016);
    // long frame format frees four more bytes
    xfer(1'b1, A_SP, 32'h0000_0010);
    xfer(1'b1, 8'hac, 32'h0000_2000);
    run(OP_RET_EXC, FORM_WORD, 32'h2, 32'h0, 32'h0, 32'h0);
    xfer(1'b0, A_SWRD, 32'h0);
    chk(rdat, 32'h0000_1234);
    xfer(1'b0, A_PC, 32'h0);
    chk(rdat, 32'h5678_9abc);
    xfer(1'b0, A_SP, 32'h0);
    chk(rdat, 32'h0000_001c);
    // list store of register 3, then list load of register 0
    run(OP_MULTI, FORM_WORD, 32'h4, 32'h0, 32'h0000_0020, 32'h0000_0008);
    xfer(1'b0, 8'hc0, 32'h0);
    chk(rdat, 32'h0000_ffff);
    xfer(1'b0, 8'hc4, 32'h0);
    chk(rdat, 32'h0000_ff80);
    run(OP_MULTI, FORM_WORD, 32'h0, 32'h0, 32'h0000_0010, 32'h0000_0001);
    xfer(1'b0, 8'h40, 32'h0);
    chk(rdat, 32'h1234_5678);
    // unmapped place still answers, with zero
    xfer(1'b0, 8'h3c, 32'h0);
    chk(rdat, 32'h0000_0000);
    report_and_stop();
  end
endmodule : cmr_core_test
